//--- pkg/asr_params.svh
// Constants of the addressable shift register chain.
// How it works
// - Sixteen-bit element shifts only when enabled.
// - Four-bit tap address picks observed position.
// - Tapped output follows address without clock.
// - Storage has no set or reset.
// - Last bit drives dedicated cascade output.
// - Cascaded elements form addressable 128-bit chain.
// - Wide muxes scale selection with element count.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

`define ASR_ELEM_BITS     16
`define ASR_ELEM_ADDR     4
`define ASR_CHAIN_ELEMS   8
`define ASR_CHAIN_SEL     3
`define ASR_BUF_DEPTH     2
`define ASR_BUF_CNT_BITS  2
`define ASR_BUF_FULL_CNT  2'h2
`define ASR_BUF_CNT_RST   2'h0
`define ASR_BUF_DATA_RST  2'h0
`define ASR_BIT_RST       1'h0
`define ASR_READY_RST     1'h1

`endif

//--- pkg/asr_pkg.sv
// Types of the addressable shift register chain.
`include "asr_params.svh"
package asr_pkg;

    typedef struct packed {
        logic [`ASR_ELEM_BITS-1:0] bits;
    } asr_elem_state_type;

    typedef struct packed {
        logic [`ASR_BUF_DEPTH-1:0]    buf_data;
        logic [`ASR_BUF_CNT_BITS-1:0] buf_cnt;
        logic                         in_ready;
        logic                         out_valid;
        logic                         tap_reg;
    } asr_chain_state_type;

endpackage

//--- rtl/asr_shift_element.sv
// One sixteen-bit addressable shift element with cascade output.
`timescale 1ns/100ps
`include "asr_params.svh"
module asr_shift_element (
    input  wire logic                      sys_clk_i,
    input  wire logic                      ce_i,
    input  wire logic                      shift_i,
    input  wire logic                      data_i,
    input  wire logic [`ASR_ELEM_ADDR-1:0] addr_i,
    output logic                           tap_o,
    output logic                           cascade_o
);

    asr_pkg::asr_elem_state_type st_reg;
    asr_pkg::asr_elem_state_type st_next;

    // ----------------------------------------------------------------
    // Shift logic
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (ce_i && shift_i) begin
            st_next.bits = {st_reg.bits[`ASR_ELEM_BITS-2:0], data_i};
        end
    end

    // Storage is deliberately left without any reset term.
    always_ff @(posedge sys_clk_i) begin
        st_reg <= st_next;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign tap_o     = st_reg.bits[addr_i];
    assign cascade_o = st_reg.bits[`ASR_ELEM_BITS-1];

endmodule // asr_shift_element

//--- rtl/asr_chain.sv
// Cascaded addressable shift register chain with registered read and drain buffer.
`timescale 1ns/100ps
`include "asr_params.svh"
module asr_chain #(
    parameter int ELEMS    = `ASR_CHAIN_ELEMS,
    parameter int SEL_BITS = `ASR_CHAIN_SEL
) (
    input  wire logic                               sys_clk_i,
    input  wire logic                               reset_i,
    input  wire logic                               ce_i,
    input  wire logic                               shift_en_i,
    input  wire logic                               data_i,
    input  wire logic [SEL_BITS+`ASR_ELEM_ADDR-1:0] addr_i,
    output logic                                    tap_o,
    output logic                                    tap_reg_o,
    output logic                                    cascade_o,
    output logic                                    in_ready_o,
    output logic                                    out_valid_o,
    output logic                                    out_data_o,
    input  wire logic                               out_ready_i
);

    asr_pkg::asr_chain_state_type st_reg;
    asr_pkg::asr_chain_state_type st_next;

    logic [ELEMS-1:0] elem_tap;
    logic [ELEMS-1:0] elem_casc;
    logic [ELEMS-1:0] elem_din;
    logic             shift;
    logic             pop;
    logic             tap_sel;

    // ----------------------------------------------------------------
    // Element chain
    // ----------------------------------------------------------------
    // A shift waits while the drain buffer is full, so no word falls off.
    assign shift = ce_i && shift_en_i && st_reg.in_ready;

    genvar gi;
    generate
        for (gi = 0; gi < ELEMS; gi++) begin : g_elem
            if (gi == 0) begin : g_first
                assign elem_din[gi] = data_i;
            end else begin : g_next
                assign elem_din[gi] = elem_casc[gi-1];
            end
            asr_shift_element u_elem (
                .sys_clk_i (sys_clk_i),
                .ce_i      (ce_i),
                .shift_i   (shift),
                .data_i    (elem_din[gi]),
                .addr_i    (addr_i[`ASR_ELEM_ADDR-1:0]),
                .tap_o     (elem_tap[gi]),
                .cascade_o (elem_casc[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Wide tap selection
    // ----------------------------------------------------------------
    // Upper address bits pick the element, one mux level per doubling.
    assign tap_sel = elem_tap[addr_i[SEL_BITS+`ASR_ELEM_ADDR-1:`ASR_ELEM_ADDR]];

    // ----------------------------------------------------------------
    // Registered read and drain buffer
    // ----------------------------------------------------------------
    assign pop = ce_i && st_reg.out_valid && out_ready_i;

    always_comb begin
        logic [`ASR_BUF_CNT_BITS-1:0] cnt;
        logic [`ASR_BUF_DEPTH-1:0]    data;
        cnt = st_reg.buf_cnt;
        data = st_reg.buf_data;
        st_next = st_reg;
        if (ce_i) begin
            if (shift) begin
                st_next.tap_reg = tap_sel;
            end
            if (pop) begin
                data = {1'b0, data[`ASR_BUF_DEPTH-1:1]};
                cnt = cnt - 2'h1;
            end
            if (shift) begin
                data[cnt[0]] = elem_casc[ELEMS-1];
                cnt = cnt + 2'h1;
            end
            st_next.buf_data  = data;
            st_next.buf_cnt   = cnt;
            st_next.out_valid = (cnt != `ASR_BUF_CNT_RST);
            st_next.in_ready  = (cnt != `ASR_BUF_FULL_CNT);
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg.buf_data  <= `ASR_BUF_DATA_RST;
            st_reg.buf_cnt   <= `ASR_BUF_CNT_RST;
            st_reg.in_ready  <= `ASR_READY_RST;
            st_reg.out_valid <= `ASR_BIT_RST;
            st_reg.tap_reg   <= `ASR_BIT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign tap_o       = tap_sel;
    assign tap_reg_o   = st_reg.tap_reg;
    assign cascade_o   = elem_casc[ELEMS-1];
    assign in_ready_o  = st_reg.in_ready;
    assign out_valid_o = st_reg.out_valid;
    assign out_data_o  = st_reg.buf_data[0];

endmodule // asr_chain

//--- tb/asr_chain_props.sv
// Checker of the chain's buffer handshake, tap register capture and storage hold.
`timescale 1ns/100ps
module asr_chain_props (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic shift_en_i,
    input wire logic tap_o,
    input wire logic tap_reg_o,
    input wire logic cascade_o,
    input wire logic in_ready_o,
    input wire logic out_valid_o,
    input wire logic out_data_o,
    input wire logic out_ready_i
);
    wire acc = ce_i & shift_en_i & in_ready_o;
    wire pop = ce_i & out_valid_o & out_ready_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    push_sets_valid_a: assert property (acc |=> out_valid_o) else $error("no word");
    head_holds_a: assert property (out_valid_o && !pop |=> out_valid_o)
        else $error("lost");
    ce_freeze_a: assert property (!ce_i |=> $stable(out_valid_o) && $stable(in_ready_o))
        else $error("moved without enable");
    stall_holds_a: assert property (!in_ready_o && !pop |=> !in_ready_o)
        else $error("stall");
    ready_returns_a: assert property (!in_ready_o && pop |=> in_ready_o)
        else $error("ready");
    full_has_word_a: assert property (!in_ready_o |-> out_valid_o) else $error("full");
    last_drain_a: assert property (out_valid_o && in_ready_o && pop && !acc |=> !out_valid_o)
        else $error("drain");
    fill_stalls_a: assert property (out_valid_o && in_ready_o && acc && !pop |=> !in_ready_o)
        else $error("fill");
    tap_capture_a: assert property (acc |=> tap_reg_o === $past(tap_o))
        else $error("tap capture");
    tap_hold_a: assert property (!acc |=> tap_reg_o === $past(tap_reg_o))
        else $error("tap moved");
    storage_hold_a: assert property (!acc |=> cascade_o === $past(cascade_o))
        else $error("storage moved");
    first_word_a: assert property (acc && !out_valid_o |=> out_data_o === $past(cascade_o))
        else $error("first word");
endmodule // asr_chain_props
bind asr_chain asr_chain_props chk (.sys_clk_i, .reset_i, .ce_i, .shift_en_i, .tap_o, .tap_reg_o,
    .cascade_o, .in_ready_o, .out_valid_o, .out_data_o, .out_ready_i);

//--- tb/asr_sink.sv
// Receiver model that drains the output buffer with stalls.
`timescale 1ns/100ps
module asr_sink (
    input  wire logic sys_clk_i,
    input  wire logic stall_i,
    output logic      ready_o
);
    initial ready_o = 1'b0;
    always @(posedge sys_clk_i) ready_o <= !stall_i;
endmodule // asr_sink

//--- tb/testbench.sv
// Random self-checking bench of the addressable shift chain.
`timescale 1ns/100ps
`include "asr_params.svh"
module testbench;
    logic sys_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b0, shift_en_i = 1'b0, data_i = 1'b0;
    logic [6:0] addr_i = 7'h00;
    logic stall = 1'b0, out_ready_i, tap_o, tap_reg_o, cascade_o, in_ready_o, out_valid_o;
    logic out_data_o, exp_tr = 1'b0, chk_tr = 1'b0, q[$];
    logic [127:0] chain;
    int n_mismatch = 0, num_checks = 0, seed = 32'hc4f1_6096;
    always #10 sys_clk_i = ~sys_clk_i;
    asr_chain dut (.sys_clk_i, .reset_i, .ce_i, .shift_en_i, .data_i, .addr_i, .tap_o,
        .tap_reg_o, .cascade_o, .in_ready_o, .out_valid_o, .out_data_o, .out_ready_i);
    asr_sink sink (.sys_clk_i, .stall_i(stall), .ready_o(out_ready_i));
    task automatic check(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        chk_tr <= 1'b0;
        if (!reset_i && ce_i && out_valid_o && out_ready_i) begin
            if (q[0] !== 1'bx) check("out_data_o", q[0], out_data_o);
            q.delete(0);
        end
        if (!reset_i && ce_i && shift_en_i && in_ready_o) begin
            q.push_back(chain[127]);
            exp_tr <= chain[addr_i];
            chk_tr <= chain[addr_i] !== 1'bx;
            chain = {chain[126:0], data_i};
        end
    end
    always @(negedge sys_clk_i) begin
        if (reset_i) q.delete();
        if (reset_i) check("tap_reg_o", 1'b0, tap_reg_o);
        if (reset_i) check("out_data_o", 1'b0, out_data_o);
        check("out_valid_o", q.size() != 0, out_valid_o);
        check("in_ready_o", q.size() < `ASR_BUF_DEPTH, in_ready_o);
        if (!reset_i && chain[addr_i] !== 1'bx) check("tap_o", chain[addr_i], tap_o);
        if (!reset_i && chain[127] !== 1'bx) check("cascade_o", chain[127], cascade_o);
        if (chk_tr && !reset_i) check("tap_reg_o", exp_tr, tap_reg_o);
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 2000; i++) begin
            @(posedge sys_clk_i);
            reset_i <= i >= 1000 && i < 1002;
            ce_i <= 3'($random(seed)) != 3'h0 && !(i >= 999 && i < 1002);
            shift_en_i <= i < 300 || 1'($random(seed));
            data_i <= 1'($random(seed));
            addr_i <= (i >= 300 && i < 600) ? 7'h06
                : (i % 97 == 0) ? 7'h7f : 7'($random(seed));
            stall <= (i % 400) > 330;
        end
        stop_test();
    end
    initial begin
        #(3000 * 20);
        n_mismatch++;
        stop_test();
    end
endmodule // testbench
